// File: hdl/cio_pkg.sv
// Constants and types for the configurable io cell block
`default_nettype none
package cio_pkg;
    localparam int NUM_EDGES = 4;
    localparam int CELLS_PER_EDGE = 4;
    localparam int NUM_CELLS = NUM_EDGES * CELLS_PER_EDGE;
    localparam int LOCALS_PER_EDGE = 4;
    localparam int DEC_INPUTS = CELLS_PER_EDGE + LOCALS_PER_EDGE;
    localparam int DEC_PER_EDGE_FULL = 4;
    localparam int DEC_PER_EDGE_REDUCED = 2;
    localparam int NUM_DECS = NUM_EDGES * DEC_PER_EDGE_FULL;
    localparam int DEC_HALF = DEC_INPUTS / 2;

    // APB map
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] DEC_STAT_OFF = 12'h004;
    localparam logic [11:0] PAD_STAT_OFF = 12'h008;
    localparam logic [11:0] CELL_BASE = 12'h100;
    localparam logic [11:0] DEC_BASE = 12'h200;
    localparam logic [11:0] IDX_MASK = 12'h03c;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 4;

    // Output source select
    typedef enum logic [1:0] {
        cio_out_direct,
        cio_out_invert,
        cio_out_reg,
        cio_out_decode
    } cio_out_src_t;

    // Input path select
    typedef enum logic [1:0] {
        cio_path_raw,
        cio_path_master,
        cio_path_slave,
        cio_path_off
    } cio_path_src_t;

    // Per-cell configuration word, bit 0 at out_src lsb
    typedef struct packed {
        cio_path_src_t path_second;
        cio_path_src_t path_first;
        logic tri_inv;
        logic in_fall;
        logic out_fall;
        logic in_init;
        logic out_init;
        cio_out_src_t out_src;
    } cio_cell_cfg_t;

    // Per-decoder configuration word
    typedef struct packed {
        logic split;
        logic [DEC_INPUTS-1:0] invert;
        logic [DEC_INPUTS-1:0] select;
    } cio_dec_cfg_t;

    localparam cio_cell_cfg_t CELL_CFG_RESET = '0;
    localparam cio_dec_cfg_t DEC_CFG_RESET = '0;
    localparam int CELL_CFG_W = $bits(cio_cell_cfg_t);
    localparam int DEC_CFG_W = $bits(cio_dec_cfg_t);
endpackage
`default_nettype wire

// File: hdl/cio_cell.sv
// One configurable io cell: output mux, output and input flip-flops
`timescale 1ns/100ps
`default_nettype none
module cio_cell (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire cio_pkg::cio_cell_cfg_t cfg,
    input wire logic config_done,
    input wire logic gsr,
    // Internal logic side
    input wire logic cell_clk,
    input wire logic cell_out,
    input wire logic cell_t,
    input wire logic dec_in,
    output logic path_first,
    output logic path_second,
    output logic pad_level,
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe
);
    typedef struct packed {
        logic clk_q;
        logic out_q;
        logic in_master;
        logic in_slave;
        logic pad_meta;
        logic pad_sync;
    } cio_cell_state_t;

    cio_cell_state_t st;
    cio_cell_state_t next_st;
    logic rise;
    logic fall;
    logic out_edge;
    logic in_edge;

    function automatic logic pick(cio_pkg::cio_path_src_t s,
                                  cio_cell_state_t c);
        case (s)
            cio_pkg::cio_path_raw: pick = c.pad_sync;
            cio_pkg::cio_path_master: pick = c.in_master;
            cio_pkg::cio_path_slave: pick = c.in_slave;
            default: pick = 1'b0;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        // Routed clock sampled on pclk, edges found by comparison
        rise = cell_clk & ~st.clk_q;
        fall = ~cell_clk & st.clk_q;
        out_edge = cfg.out_fall ? fall : rise;
        in_edge = cfg.in_fall ? fall : rise;
        next_st.clk_q = cell_clk;
        next_st.pad_meta = pad_in;
        next_st.pad_sync = st.pad_meta;
        if (cell_clk == cfg.in_fall) begin
            next_st.in_master = st.pad_sync;
        end
        if (in_edge) begin
            next_st.in_slave = st.in_master;
        end
        if (out_edge) begin
            next_st.out_q = cell_out;
        end
        if (!config_done || gsr) begin
            next_st.out_q = cfg.out_init;
            next_st.in_master = cfg.in_init;
            next_st.in_slave = cfg.in_init;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        case (cfg.out_src)
            cio_pkg::cio_out_direct: pad_out = cell_out;
            cio_pkg::cio_out_invert: pad_out = ~cell_out;
            cio_pkg::cio_out_reg: pad_out = st.out_q;
            default: pad_out = dec_in;
        endcase
    end

    assign pad_oe = ~(cell_t ^ cfg.tri_inv);
    assign path_first = pick(cfg.path_first, st);
    assign path_second = pick(cfg.path_second, st);
    assign pad_level = st.pad_sync;
endmodule // cio_cell
`default_nettype wire

// File: hdl/cio_decode.sv
// One wide edge decoder with optional split at its midpoint
`timescale 1ns/100ps
`default_nettype none
module cio_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire cio_pkg::cio_dec_cfg_t cfg,
    input wire logic enable,
    // Inputs and results
    input wire logic [cio_pkg::DEC_INPUTS-1:0] in_vec,
    output logic dec_out,
    output logic dec_half_out
);
    typedef struct packed {
        logic whole;
        logic upper;
    } cio_dec_state_t;

    cio_dec_state_t st;
    cio_dec_state_t next_st;
    logic [cio_pkg::DEC_INPUTS-1:0] term;
    logic lo;
    logic hi;

    always_comb begin
        term = ~cfg.select | (in_vec ^ cfg.invert);
        lo = &term[cio_pkg::DEC_HALF-1:0];
        hi = &term[cio_pkg::DEC_INPUTS-1:cio_pkg::DEC_HALF];
        next_st.whole = enable & (cfg.split ? lo : (lo & hi));
        next_st.upper = enable & cfg.split & hi;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dec_out = st.whole;
    assign dec_half_out = st.upper;
endmodule // cio_decode
`default_nettype wire

// File: hdl/cio_top.sv
// Configurable io cells and wide edge decoders behind an APB slave
// Function
// - Pad driven direct, inverted or registered
// - Flip-flops start in configured set/reset
// - Global set/reset forces configured initial state
// - Clock edge selectable per flip-flop
// - Tri-state control polarity invertible per cell
// - Pad input feeds logic and input flop
// - Two paths: raw, master or slave
// - Four decoders per edge, two reduced
// - Decoder inputs: first paths plus locals
// - AND of selected true/complemented inputs
// - Decoder splittable into two halves
// - Decoder outputs to logic and pads
`timescale 1ns/100ps
`default_nettype none
module cio_top #(
    parameter bit REDUCED_ROUTING = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cio_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Internal logic side
    input wire logic gsr,
    input wire logic [cio_pkg::NUM_CELLS-1:0] cell_clk,
    input wire logic [cio_pkg::NUM_CELLS-1:0] cell_out,
    input wire logic [cio_pkg::NUM_CELLS-1:0] cell_t,
    output logic [cio_pkg::NUM_CELLS-1:0] path_first,
    output logic [cio_pkg::NUM_CELLS-1:0] path_second,
    // Row and column locals into the decoders
    input wire logic [cio_pkg::NUM_EDGES*cio_pkg::LOCALS_PER_EDGE-1:0]
        local_in,
    output logic [cio_pkg::NUM_DECS-1:0] dec_out,
    output logic [cio_pkg::NUM_DECS-1:0] dec_half_out,
    // Pads
    input wire logic [cio_pkg::NUM_CELLS-1:0] pad_in,
    output logic [cio_pkg::NUM_CELLS-1:0] pad_out,
    output logic [cio_pkg::NUM_CELLS-1:0] pad_oe
);
    typedef struct packed {
        logic done;
        cio_pkg::cio_cell_cfg_t [cio_pkg::NUM_CELLS-1:0] cells;
        cio_pkg::cio_dec_cfg_t [cio_pkg::NUM_DECS-1:0] decs;
        logic [31:0] rdata;
        logic err;
    } cio_top_state_t;

    cio_top_state_t st;
    cio_top_state_t next_st;
    logic [cio_pkg::NUM_CELLS-1:0] pad_level;
    logic [cio_pkg::IDX_W-1:0] idx;
    logic hit_cell;
    logic hit_dec;
    logic setup;
    logic wr;

    assign idx = paddr[cio_pkg::IDX_LSB +: cio_pkg::IDX_W];
    assign hit_cell = (paddr & ~cio_pkg::IDX_MASK) == cio_pkg::CELL_BASE;
    assign hit_dec = (paddr & ~cio_pkg::IDX_MASK) == cio_pkg::DEC_BASE;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & ~st.err;

    always_comb begin
        next_st = st;
        // Read data and error are settled in the setup cycle
        if (setup) begin
            next_st.err = 1'b0;
            next_st.rdata = '0;
            if (paddr == cio_pkg::CTRL_OFF) begin
                next_st.rdata = 32'(st.done);
            end else if (paddr == cio_pkg::DEC_STAT_OFF) begin
                next_st.rdata = {dec_half_out, dec_out};
            end else if (paddr == cio_pkg::PAD_STAT_OFF) begin
                next_st.rdata = 32'(pad_level);
            end else if (hit_cell) begin
                next_st.rdata = 32'(st.cells[idx]);
            end else if (hit_dec) begin
                next_st.rdata = 32'(st.decs[idx]);
            end else begin
                next_st.err = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == cio_pkg::CTRL_OFF) begin
                next_st.done = pwdata[0];
            end else if (hit_cell) begin
                next_st.cells[idx] = cio_pkg::cio_cell_cfg_t'(
                    pwdata[cio_pkg::CELL_CFG_W-1:0]);
            end else if (hit_dec) begin
                next_st.decs[idx] = cio_pkg::cio_dec_cfg_t'(
                    pwdata[cio_pkg::DEC_CFG_W-1:0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.done <= 1'b0;
            st.cells <= {cio_pkg::NUM_CELLS{cio_pkg::CELL_CFG_RESET}};
            st.decs <= {cio_pkg::NUM_DECS{cio_pkg::DEC_CFG_RESET}};
            st.rdata <= '0;
            st.err <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Zero wait states; status words are read-only, writes ignored
    assign pready = 1'b1;
    assign prdata = st.rdata;
    assign pslverr = psel & penable & st.err;

    genvar gi;
    generate
        for (gi = 0; gi < cio_pkg::NUM_CELLS; gi++) begin : g_cell
            localparam int EDGE = gi / cio_pkg::CELLS_PER_EDGE;
            localparam int SLOT = gi % cio_pkg::CELLS_PER_EDGE;
            cio_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .cfg(st.cells[gi]),
                .config_done(st.done),
                .gsr(gsr),
                .cell_clk(cell_clk[gi]),
                .cell_out(cell_out[gi]),
                .cell_t(cell_t[gi]),
                .dec_in(dec_out[EDGE * cio_pkg::DEC_PER_EDGE_FULL + SLOT]),
                .path_first(path_first[gi]),
                .path_second(path_second[gi]),
                .pad_level(pad_level[gi]),
                .pad_in(pad_in[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe(pad_oe[gi])
            );
        end

        for (gi = 0; gi < cio_pkg::NUM_DECS; gi++) begin : g_dec
            localparam int EDGE = gi / cio_pkg::DEC_PER_EDGE_FULL;
            localparam int SLOT = gi % cio_pkg::DEC_PER_EDGE_FULL;
            // reduced member keeps two per edge
            localparam bit PRESENT = !REDUCED_ROUTING ||
                (SLOT < cio_pkg::DEC_PER_EDGE_REDUCED);
            cio_decode u_dec (
                .pclk(pclk),
                .presetn(presetn),
                .cfg(st.decs[gi]),
                .enable(PRESENT),
                .in_vec({local_in[EDGE * cio_pkg::LOCALS_PER_EDGE +:
                                  cio_pkg::LOCALS_PER_EDGE],
                         path_first[EDGE * cio_pkg::CELLS_PER_EDGE +:
                                    cio_pkg::CELLS_PER_EDGE]}),
                .dec_out(dec_out[gi]),
                .dec_half_out(dec_half_out[gi])
            );
        end
    endgenerate
endmodule // cio_top
`default_nettype wire

// File: dv/cio_props.sv
// Port checker for the io cell top, with its bind
`timescale 1ns/100ps
`default_nettype none
module cio_props (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Cells
    input wire logic gsr,
    input wire logic [15:0] cell_out,
    input wire logic [15:0] cell_t,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe
);
    logic [10:0] cfg [16];
    logic done;
    logic [15:0] oe_x, dm, dx, rm, iv;
    wire logic setup = psel && !penable;
    wire logic grp = paddr[11:6] == 6'h04 || paddr[11:6] == 6'h08;
    wire logic ok = paddr[1:0] == 2'h0 && (grp || paddr < 12'h00c);
    // Shadow of the cell config words and done bit written over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
            for (int i = 0; i < 16; i++) cfg[i] <= '0;
        end else if (psel && penable && pwrite && ok) begin
            if (paddr == 12'h000) done <= pwdata[0];
            if (paddr[11:6] == 6'h04) cfg[paddr[5:2]] <= pwdata[10:0];
        end
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            oe_x[i] = ~(cell_t[i] ^ cfg[i][6]);
            dm[i] = !cfg[i][1];
            dx[i] = cell_out[i] ^ cfg[i][0];
            rm[i] = cfg[i][1:0] == 2'h2;
            iv[i] = cfg[i][2];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_bad;
        setup && !ok ##1 psel && penable;
    endsequence
    sequence s_good;
        setup && ok ##1 psel && penable;
    endsequence
    sequence s_ctrl;
        setup && !pwrite && paddr == 12'h000 ##1 psel && penable;
    endsequence
    sequence s_cell;
        setup && !pwrite && ok && paddr[11:6] == 6'h04 ##1 psel && penable;
    endsequence
    property p_ready;
        pready;
    endproperty
    property p_err;
        s_bad |-> pslverr && prdata == '0;
    endproperty
    property p_noerr;
        s_good |-> !pslverr;
    endproperty
    property p_ctrl;
        s_ctrl |-> prdata == {31'h0, done};
    endproperty
    property p_cfgrd;
        s_cell |-> prdata[10:0] == cfg[paddr[5:2]];
    endproperty
    property p_oe;
        pad_oe == oe_x;
    endproperty
    property p_mux;
        (dm & (pad_out ^ dx)) == '0;
    endproperty
    // Init must be stable too, else the flop still shows the old one
    property p_init;
        ((gsr || !done) && $stable(iv) && $stable(rm))[*2]
            |-> (rm & (pad_out ^ iv)) == '0;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_err: assert property (p_err) else $error("unmapped not refused");
    a_noerr: assert property (p_noerr) else $error("mapped refused");
    a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
    a_cfgrd: assert property (p_cfgrd) else $error("cell readback");
    a_oe: assert property (p_oe) else $error("oe polarity");
    a_mux: assert property (p_mux) else $error("pad mux");
    a_init: assert property (p_init) else $error("flop init");
endmodule // cio_props
bind cio_top cio_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gsr(gsr), .cell_out(cell_out), .cell_t(cell_t), .pad_out(pad_out),
    .pad_oe(pad_oe));
`default_nettype wire

// File: dv/cio_board.sv
// Board model on the pad side
`timescale 1ns/100ps
`default_nettype none
module cio_board (
    // Clock
    input wire logic pclk,
    // Board drivers
    input wire logic [15:0] drv_en,
    input wire logic [15:0] drv_val,
    // Pads
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe,
    output logic [15:0] pad_in
);
    // Undriven pads toggle, so a stale level never reads as valid
    logic [15:0] flt = '0;
    always_ff @(posedge pclk) flt <= ~flt;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv_val)
        | (~pad_oe & ~drv_en & flt);
endmodule // cio_board
`default_nettype wire

// File: dv/tb_top.sv
// Bench for the io cell block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gsr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] cclk, cout, ct, pf, ps, lin, dout, dhout;
    logic [15:0] pin, pout, poe, den, dval, dred;
    logic [31:0] cw [16] = '{1: 32'h1, 2: 32'h6, 3: 32'h3, 4: 32'h12,
        5: 32'h40, 8: 32'h400, 9: 32'h680, 10: 32'h428, default: 32'h0};
    int num_errors = 0;
    int check_count = 0;
    cio_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gsr(gsr),
        .cell_clk(cclk), .cell_out(cout), .cell_t(ct), .path_first(pf),
        .path_second(ps), .local_in(lin), .dec_out(dout),
        .dec_half_out(dhout), .pad_in(pin), .pad_out(pout), .pad_oe(poe));
    // Reduced member, same stimulus: only two decoders per edge
    cio_top #(.REDUCED_ROUTING(1'b1)) u_red (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .gsr(gsr), .cell_clk(cclk), .cell_out(cout), .cell_t(ct),
        .path_first(), .path_second(), .local_in(lin), .dec_out(dred),
        .dec_half_out(), .pad_in(pin), .pad_out(), .pad_oe());
    cio_board u_board (.pclk(pclk), .drv_en(den), .drv_val(dval),
        .pad_out(pout), .pad_oe(poe), .pad_in(pin));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic check(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Cell clock seen a cycle late, so each level gets four cycles
    task automatic pulse(input int c);
        @(posedge pclk) cclk[c] <= 1'b1;
        idle(3);
        @(posedge pclk) cclk[c] <= 1'b0;
        idle(3);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, gsr} = '0;
        paddr = '0;
        pwdata = '0;
        {cclk, cout, lin, dval} = '0;
        ct = '1;
        den = '1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        idle(1);
        check("oe", poe, {16'h0, ~ct});
        check("dec", dout, 32'hffff);
        check("red", dred, 32'h3333);
        bus(1'b0, 12'h000, '0);
        check("ctrl", rdat, 32'h0);
        bus(1'b0, 12'hffc, '0);
        check("err", rerr, 1'b1);
        check("errd", rdat, 32'h0);
        for (int i = 0; i < 16; i++) bus(1'b1, 12'h100 + 12'(4 * i), cw[i]);
        bus(1'b1, 12'h210, 32'h1010);
        bus(1'b1, 12'h214, 32'h12021);
        bus(1'b0, 12'h124, '0);
        check("cfg", rdat[10:0], 11'h680);
        for (int v = 0; v < 2; v++) begin
            @(posedge pclk) cout[1:0] <= v[0] ? 2'h3 : 2'h0;
            idle(1);
            check("mux", pout[1:0], v[0] ? 2'h1 : 2'h2);
        end
        check("dpad", pout[3], 1'b1);
        pulse(2);
        check("init", pout[2], 1'b1);
        check("tri", poe, {16'h0, ~ct ^ 16'h0020});
        bus(1'b1, 12'h000, 32'h1);
        pulse(2);
        check("capt", pout[2], 1'b0);
        @(posedge pclk) cout[2] <= 1'b1;
        idle(3);
        check("hold", pout[2], 1'b0);
        @(posedge pclk) gsr <= 1'b1;
        idle(2);
        check("gsr", pout[2], 1'b1);
        @(posedge pclk) gsr <= 1'b0;
        cout[4] <= 1'b1;
        cclk[4] <= 1'b1;
        idle(3);
        check("rise", pout[4], 1'b0);
        @(posedge pclk) cclk[4] <= 1'b0;
        dval[9:8] <= 2'h3;
        dval[4] <= 1'b1;
        idle(5);
        check("fall", pout[4], 1'b1);
        check("raw", pf[9:8], 2'h3);
        check("sec", ps[10:8], 3'h4);
        pulse(8);
        check("slave", ps[8], 1'b1);
        @(posedge pclk) dval[8] <= 1'b0;
        idle(5);
        check("raw0", pf[8], 1'b0);
        check("shold", ps[8], 1'b1);
        // Falling-active input flop: master open while clock high
        @(posedge pclk) cclk[10] <= 1'b1;
        idle(3);
        check("frise", ps[10], 1'b1);
        @(posedge pclk) cclk[10] <= 1'b0;
        idle(3);
        check("ffall", ps[10], 1'b0);
        bus(1'b0, 12'h008, '0);
        check("pads", rdat[9:8], 2'h2);
        bus(1'b0, 12'h004, '0);
        check("stat", {rdat[21], rdat[5:4]}, 3'h7);
        @(posedge pclk) lin[5:4] <= 2'h3;
        idle(2);
        check("dand", dout[5:4], 2'h2);
        check("half", dhout[5], 1'b0);
        @(posedge pclk) dval[4] <= 1'b0;
        idle(5);
        check("dpath", dout[5], 1'b0);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
